// ===== shared/match_timer_pkg.sv
// Constants for the ten-bit match timer
package match_timer_pkg;
  localparam int COUNT_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFF_STATUS_CONTROL = 8'hb0;
  localparam logic [7:0] OFF_CONFIG = 8'hb1;
  localparam logic [7:0] OFF_ONE_HIGH = 8'hb2;
  localparam logic [7:0] OFF_ONE_LOW = 8'hb3;
  localparam logic [7:0] OFF_TWO_HIGH = 8'hb4;
  localparam logic [7:0] OFF_TWO_LOW = 8'hb5;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'hbe;
  localparam logic [7:0] OFF_COUNT_LOW = 8'hbf;
  // Status/control fields
  localparam int BIT_RUN = 0;
  localparam int BIT_CH1 = 1;
  localparam int BIT_CH2 = 2;
  // Config fields
  localparam int SRC_LO = 2;
  localparam int SRC_HI = 3;
  localparam int PRI_LO = 0;
  localparam int PRI_HI = 1;
  localparam logic [1:0] SRC_HALF = 2'h0;
  localparam logic [1:0] SRC_SIBLING = 2'h1;
  localparam logic [3:0] CONFIG_RESET = 4'h0;
  localparam logic [2:0] CSR_RESET = 3'h0;
  // High byte carries compare bits in 7:6
  localparam int HIGH_POS = 6;
  // Prescaler figures
  localparam int HALF_DIV = 2;
  localparam int EIGHTH_DIV = 8;
  localparam int PRESCALE_W = 3;
endpackage

// ===== logic/match_channel.sv
// One compare channel: preload, active match value, match pulse, arming
`timescale 1ns/1ps
module match_channel #(
  parameter int COUNT_W = 10
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Register writes
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [1:0] high_data,
  input wire logic [7:0] low_data,
  input wire logic status_clear,
  // Counter
  input wire logic count_step,
  input wire logic [COUNT_W-1:0] next_count,
  // Results
  output logic match_pulse,
  output logic status,
  output logic armed
);
  logic [COUNT_W-1:0] preload;
  logic [COUNT_W-1:0] active;
  logic hit;

  ////////////////////////////////////////////////////////////////
  // continuous comparison
  assign hit = count_step && (next_count == active);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= hit;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      preload <= '0;
    end else begin
      if (wr_high) begin
        preload[COUNT_W-1:8] <= high_data;
      end
      if (wr_low) begin
        preload[7:0] <= low_data;
      end
    end
  end

  // preload moves to active match on the pulse
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      active <= '0;
    end else if (hit) begin
      active <= preload;
    end
  end

  // match marks low preload invalid; only low write rearms
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      armed <= 1'b0;
    end else if (hit) begin
      armed <= 1'b0;
    end else if (wr_low) begin
      armed <= 1'b1;
    end
  end

  // status set on match wins over read clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= 1'b0;
    end else if (hit) begin
      status <= 1'b1;
    end else if (status_clear) begin
      status <= 1'b0;
    end
  end

  a_pulse_single: assert property (@(posedge CLK) disable iff (!ARST_N)
    match_pulse |=> !match_pulse) else $error("match pulse longer than one cycle");
  a_pulse_cause: assert property (@(posedge CLK) disable iff (!ARST_N)
    hit |=> match_pulse && status) else $error("match did not pulse");
  a_transfer_load: assert property (@(posedge CLK) disable iff (!ARST_N)
    hit |=> active == $past(preload)) else $error("preload not transferred");
  a_disarm_match: assert property (@(posedge CLK) disable iff (!ARST_N)
    hit |=> !armed) else $error("channel still armed after match");
  a_rearm_low: assert property (@(posedge CLK) disable iff (!ARST_N)
    (!armed && !wr_low) |=> !armed) else $error("rearmed without low write");
endmodule

// ===== logic/match_timer.sv
// Ten-bit free-running match timer with two compare channels
//
// Functional notes
// - Counter advances from half clock, half clock over eight, or sibling pulse.
// - Config bits 3:2: 00 half-rate clock, 1x half-rate divided by eight.
// - Ten-bit up counter wraps and runs while its clock is enabled.
// - Counter is compared continuously against two independent match values.
// - Reaching a match value yields a one-cycle match pulse per channel.
// - Each match pulse leaves the block as a strobe for interrupts and ports.
// - Writes go to preload; the match pulse moves preload into active match.
// - Every match marks the low preload invalid, blocking further interrupts.
// - Only a new low-byte preload write re-enables that channel interrupt.
// - Reading status/control clears both match bits and pending interrupts.
// - Status/control write bits 2 and 1 enable second and first interrupts.
// - Status/control bit 0 runs (1) or stops (0) the counter clock.
// - Status/control bits 7:3 always read zero.
// - Config bits 1:0: 00 no interrupts, else priority level one to three.
// - High preload stores write bits 7:6; bits 5:0 read zero.
// - Low preload stores write bits 7:0 until the next low-byte write.
// - Count high read gives counter bits 9:8 in 7:6, zeros below.
// - Count low read gives counter bits 7:0.
// - Reset clears status/control bits 2:0 and config bits 3:0.
`timescale 1ns/1ps
module match_timer
  import match_timer_pkg::*;
#(
  parameter int COUNT_BITS = 10
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Processor I/O bus
  input wire logic [match_timer_pkg::ADDR_W-1:0] ADDR,
  input wire logic [match_timer_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [match_timer_pkg::DATA_W-1:0] RDATA,
  // Sibling timer pulse, same clock
  input wire logic SIBLING_PULSE,
  // Match strobes for parallel ports
  output logic MATCH_ONE,
  output logic MATCH_TWO,
  // Interrupt request
  output logic IRQ,
  output logic [1:0] IRQ_PRIORITY
);
  import match_timer_pkg::*;

  logic run;
  logic [1:0] int_enable;
  logic [1:0] source;
  logic [1:0] priority_level;
  logic [PRESCALE_W-1:0] eighth_count;
  logic half_phase;
  logic half_tick;
  logic eighth_tick;
  logic count_step;
  logic [COUNT_BITS-1:0] count;
  logic [COUNT_BITS-1:0] next_count;
  logic status_read;
  logic [1:0] status;
  logic [1:0] armed;
  logic [1:0] pending;
  logic [1:0] pulses;
  logic [1:0] armed_at_hit;

  ////////////////////////////////////////////////////////////////
  // Register writes
  // reset stops clock, clears enables
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {int_enable, run} <= CSR_RESET;
    end else if (WR && ADDR == OFF_STATUS_CONTROL) begin
      run <= WDATA[BIT_RUN];
      int_enable <= {WDATA[BIT_CH2], WDATA[BIT_CH1]};
    end
  end

  // source and priority; bits 7:4 are not stored
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {source, priority_level} <= CONFIG_RESET;
    end else if (WR && ADDR == OFF_CONFIG) begin
      source <= WDATA[SRC_HI:SRC_LO];
      priority_level <= WDATA[PRI_HI:PRI_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Prescaler: half rate then divide by eight
  // half-rate tick from the peripheral clock
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      half_phase <= 1'b0;
    end else if (run) begin
      half_phase <= ~half_phase;
    end
  end
  assign half_tick = run && half_phase;

  // eighth of the half-rate tick
  // Runs in every source mode, so the first eighth step after a switch may come early
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      eighth_count <= '0;
    end else if (half_tick) begin
      eighth_count <= eighth_count + 1'b1;
    end
  end
  assign eighth_tick = half_tick && (eighth_count == PRESCALE_W'(EIGHTH_DIV - 1));

  // Sibling pulses share this clock, so they need no synchroniser
  // step source: eighth, sibling or half rate; nothing steps while stopped
  always_comb begin
    count_step = 1'b0;
    if (run) begin
      if (source[1]) begin
        count_step = eighth_tick;
      end else if (source == SRC_SIBLING) begin
        count_step = SIBLING_PULSE;
      end else begin
        count_step = half_tick;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Counter
  // ten-bit wrapping up counter
  // Wraps from all ones to zero by plain overflow
  assign next_count = count + 1'b1;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= '0;
    end else if (count_step) begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Compare channels
  // any status/control read clears the match bits
  assign status_read = RD && ADDR == OFF_STATUS_CONTROL;

  match_channel #(.COUNT_W(COUNT_BITS)) u_one (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .wr_high(WR && ADDR == OFF_ONE_HIGH),
    .wr_low(WR && ADDR == OFF_ONE_LOW),
    .high_data(WDATA[7:HIGH_POS]),
    .low_data(WDATA),
    .status_clear(status_read),
    .count_step(count_step),
    .next_count(next_count),
    .match_pulse(pulses[0]),
    .status(status[0]),
    .armed(armed[0])
  );

  match_channel #(.COUNT_W(COUNT_BITS)) u_two (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .wr_high(WR && ADDR == OFF_TWO_HIGH),
    .wr_low(WR && ADDR == OFF_TWO_LOW),
    .high_data(WDATA[7:HIGH_POS]),
    .low_data(WDATA),
    .status_clear(status_read),
    .count_step(count_step),
    .next_count(next_count),
    .match_pulse(pulses[1]),
    .status(status[1]),
    .armed(armed[1])
  );

  assign MATCH_ONE = pulses[0];
  assign MATCH_TWO = pulses[1];

  ////////////////////////////////////////////////////////////////
  // Interrupt request
  // Pending is a level held until a status read, so a slow handler still sees it
  // a pending interrupt needs the channel armed when it matched
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pending <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pulses[i] && armed_at_hit[i]) begin
          pending[i] <= 1'b1;
        end else if (status_read) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  // Armed state sampled at the match, since the channel disarms on that edge
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      armed_at_hit <= 2'h0;
    end else begin
      armed_at_hit <= armed;
    end
  end

  // priority zero silences the block; enables gate each channel
  assign IRQ = (priority_level != 2'h0) && |(pending & int_enable);
  assign IRQ_PRIORITY = priority_level;

  ////////////////////////////////////////////////////////////////
  // Read data
  // Data follows ADDR every cycle; the count bytes are read apart, so software must handle a carry
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else begin
      case (ADDR)
        OFF_STATUS_CONTROL: RDATA <= {5'h00, status, 1'b0};
        OFF_COUNT_HIGH: RDATA <= {count[COUNT_BITS-1:8], 6'h00};
        OFF_COUNT_LOW: RDATA <= count[7:0];
        default: RDATA <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  // Eighth-rate spacing, as a step followed by quiet cycles
  sequence s_eighth_step;
    run && source[1] && count_step;
  endsequence

  sequence s_eighth_quiet;
    (!count_step || !(run && source[1])) [*8];
  endsequence

  // Armed match on channel one while its request path is open and untouched
  sequence s_armed_hit_one;
    pulses[0] && armed_at_hit[0] && int_enable[0] && (priority_level != 2'h0) && !WR;
  endsequence

  a_stop_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
    !run |=> count == $past(count) && !MATCH_ONE && !MATCH_TWO) else $error("counter moved while stopped");
  a_half_rate: assert property (@(posedge CLK) disable iff (!ARST_N)
    (run && source == SRC_HALF && count_step) ##1 (run && source == SRC_HALF)
      |-> !count_step) else $error("half rate stepped twice in a row");
  a_eighth_rate: assert property (@(posedge CLK) disable iff (!ARST_N)
    s_eighth_step |=> s_eighth_quiet) else $error("eighth rate stepped too soon");
  a_sibling_step: assert property (@(posedge CLK) disable iff (!ARST_N)
    (run && source == SRC_SIBLING && SIBLING_PULSE) |=> count == $past(count) + 1'b1)
    else $error("sibling pulse did not step");

  a_read_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
    (status_read && !pulses[0] && !pulses[1]) |=> pending == 2'h0) else $error("read left interrupt pending");
  a_irq_raise: assert property (@(posedge CLK) disable iff (!ARST_N)
    s_armed_hit_one |=> IRQ) else $error("armed match raised no interrupt");
  a_disarmed_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
    (pulses[0] && !armed_at_hit[0] && !pending[0]) |=> !pending[0]) else $error("disarmed match set a request");
  a_irq_off: assert property (@(posedge CLK) disable iff (!ARST_N)
    priority_level == 2'h0 |-> !IRQ) else $error("interrupt with priority zero");

  a_enable_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    (WR && ADDR == OFF_STATUS_CONTROL) |=> int_enable == $past(WDATA[BIT_CH2:BIT_CH1]))
    else $error("interrupt enables not written");
  a_run_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    (WR && ADDR == OFF_STATUS_CONTROL) |=> run == $past(WDATA[BIT_RUN])) else $error("run bit not written");
  a_config_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    (WR && ADDR == OFF_CONFIG) |=> priority_level == $past(WDATA[PRI_HI:PRI_LO])
      && source == $past(WDATA[SRC_HI:SRC_LO])) else $error("config write not taken");
  a_reset_clear: assert property (@(posedge CLK)
    !ARST_N |-> {int_enable, run} == CSR_RESET && {source, priority_level} == CONFIG_RESET) else $error("reset left control set");

  a_status_read: assert property (@(posedge CLK) disable iff (!ARST_N)
    (RD && ADDR == OFF_STATUS_CONTROL) |=> RDATA == {5'h00, $past(status), 1'b0})
    else $error("status readback wrong");
  a_count_high: assert property (@(posedge CLK) disable iff (!ARST_N)
    (RD && ADDR == OFF_COUNT_HIGH) |=> RDATA == {$past(count[COUNT_BITS-1:8]), 6'h00})
    else $error("count high readback wrong");
  a_count_low: assert property (@(posedge CLK) disable iff (!ARST_N)
    (RD && ADDR == OFF_COUNT_LOW) |=> RDATA == $past(count[7:0])) else $error("count low readback wrong");
endmodule

// ===== verif/sibling_pulse_model.sv
// Sibling timer stand-in: one-cycle pulse every PERIOD clocks
`timescale 1ns/1ps
module sibling_pulse_model #(
  parameter int PERIOD = 3
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Pulse out
  output logic PULSE
);
  int cnt;
  // Free running, so the step rate seen by the timer is exactly one per PERIOD
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= 0;
      PULSE <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      PULSE <= (cnt == PERIOD - 1);
    end
  end
endmodule

// ===== verif/ten_bit_match_timer_tb.sv
// Register-level bench for the ten-bit match timer
`timescale 1ns/1ps
module ten_bit_match_timer_tb;
  import match_timer_pkg::*;
  localparam int SIB = 3;
  logic clk, arst_n, wr, rd, sib, m1, m2, irq;
  logic [7:0] addr, wdata, rdata, a, b;
  logic [1:0] pri;
  int cyc, err_count, comparisons, t1, t2, t3, p;

  ////////////////////////////////////////////////////////////////
  match_timer dut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SIBLING_PULSE(sib), .MATCH_ONE(m1), .MATCH_TWO(m2), .IRQ(irq), .IRQ_PRIORITY(pri));
  sibling_pulse_model #(.PERIOD(SIB)) sib_model (.CLK(clk), .ARST_N(arst_n), .PULSE(sib));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc >= 80000) begin
      err_count++;
      complete_run;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compares %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_int(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    #5 addr = ad;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #5 wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    #5 addr = ad;
    rd = 1'b1;
    @(posedge clk);
    #5 rd = 1'b0;
    d = rdata;
  endtask

  // Returns the cycle stamp of the next strobe on the chosen channel
  task automatic wait_hit(input logic two, output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((two ? m2 : m1) !== 1'b1 && n < 20000);
    if ((two ? m2 : m1) !== 1'b1) begin
      err_count++;
      $display("BAD strobe wait expected %h seen %h", 1'b1, 1'b0);
    end
    t = cyc;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (10) @(posedge clk);
    #5 arst_n = 1'b1;
    rd_reg(OFF_STATUS_CONTROL, a);
    chk8("status reset", 8'h00, a);
    chk8("priority reset", 8'h00, {6'h00, pri});
    rd_reg(8'hc0, a);
    chk8("unmapped", 8'h00, a);
    rd_reg(OFF_COUNT_LOW, a);
    repeat (20) @(posedge clk);
    rd_reg(OFF_COUNT_LOW, b);
    chk8("count held", a, b);
    for (p = 3; p >= 0; p--) begin
      wr_reg(OFF_CONFIG, 8'(p));
      chk8("priority", 8'(p), {6'h00, pri});
    end
    wr_reg(OFF_CONFIG, 8'h01);
    // Preload 0x105, high byte first
    wr_reg(OFF_ONE_HIGH, 8'h40);
    wr_reg(OFF_ONE_LOW, 8'h05);
    wr_reg(OFF_STATUS_CONTROL, 8'h03);
    rd_reg(OFF_COUNT_LOW, a);
    repeat (8) @(posedge clk);
    rd_reg(OFF_COUNT_LOW, b);
    chk8("count step", a + 8'h05, b);
    rd_reg(OFF_COUNT_HIGH, a);
    chk8("count high low bits", 8'h00, a & 8'h3f);
    wait_hit(1'b0, t1);
    // The request follows the strobe by one cycle
    @(posedge clk);
    #1 chk8("strobe width", 8'h00, {7'h00, m1});
    chk8("irq on match", 8'h01, {7'h00, irq});
    rd_reg(OFF_STATUS_CONTROL, a);
    chk8("status both", 8'h06, a);
    chk8("irq cleared", 8'h00, {7'h00, irq});
    // High byte alone must not re-arm
    wr_reg(OFF_ONE_HIGH, 8'h40);
    wait_hit(1'b0, t2);
    chk_int("preload interval", 2 * 261, t2 - t1);
    @(posedge clk);
    #1 chk8("irq disarmed", 8'h00, {7'h00, irq});
    rd_reg(OFF_COUNT_HIGH, a);
    chk8("count high", 8'h40, a);
    rd_reg(OFF_STATUS_CONTROL, a);
    chk8("status one", 8'h02, a);
    wr_reg(OFF_ONE_LOW, 8'h05);
    wait_hit(1'b0, t3);
    chk_int("wrap interval", 2 * 1024, t3 - t2);
    @(posedge clk);
    #1 chk8("irq rearmed", 8'h01, {7'h00, irq});
    // Priority zero hides a pending request, which comes back with a level
    wr_reg(OFF_CONFIG, 8'h00);
    chk8("irq priority off", 8'h00, {7'h00, irq});
    // Eighth rate, channel two at 0
    wr_reg(OFF_CONFIG, 8'h09);
    chk8("irq priority back", 8'h01, {7'h00, irq});
    wait_hit(1'b1, t1);
    wait_hit(1'b1, t2);
    wait_hit(1'b1, t3);
    chk_int("eighth interval", 16 * 1024, t3 - t2);
    wr_reg(OFF_CONFIG, 8'h05);
    wait_hit(1'b1, t1);
    wait_hit(1'b1, t2);
    wait_hit(1'b1, t3);
    chk_int("sibling interval", SIB * 1024, t3 - t2);
    complete_run;
  end
endmodule
